/* hdl/readout_pkg.sv */
// Constants, types and state layout of the readout window block
package readout_pkg;
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_H_START = 8'h00;
  localparam logic [7:0] OFS_V_START = 8'h04;
  localparam logic [7:0] OFS_WIDTH   = 8'h08;
  localparam logic [7:0] OFS_HEIGHT  = 8'h0C;
  localparam logic [7:0] OFS_PITCH   = 8'h10;
  localparam logic [7:0] OFS_PACKING = 8'h14;
  localparam logic [7:0] OFS_BINNING = 8'h18;
  localparam logic [7:0] OFS_DEPTH   = 8'h1C;
  localparam logic [7:0] OFS_FLINES  = 8'h20;
  localparam logic [7:0] OFS_MARGIN  = 8'h24;
  // Field positions in the binning register
  localparam int BIN_H_BIT = 0;
  localparam int BIN_V_BIT = 1;
  // Window geometry
  localparam logic [10:0] OB_TOP       = 11'h004;
  localparam logic [10:0] OB_SIDE_FULL = 11'h010;
  localparam logic [10:0] OB_SIDE_BIN  = 11'h008;
  localparam logic [10:0] MAX_W_1      = 11'h660;
  localparam logic [10:0] MAX_W_2      = 11'h330;
  localparam logic [10:0] MAX_H_1      = 11'h4B4;
  localparam logic [10:0] MAX_H_2      = 11'h25C;
  // Reset values: active image only, no margins
  localparam logic [10:0] RST_H_START = 11'h010;
  localparam logic [10:0] RST_V_START = 11'h004;
  localparam logic [10:0] RST_WIDTH   = 11'h640;
  localparam logic [10:0] RST_HEIGHT  = 11'h4B0;
  // Frame line arithmetic terms
  localparam int FL_BASE    = 1203;
  localparam int FL_ADD_LO  = 29;
  localparam int FL_ADD_HI  = 28;
  localparam int FL_ADD_BIN = 24;
  // Line times in ns and the clock period they are counted in
  localparam int CLK_NS       = 20;
  localparam int LINE_NS_1    = 20040;
  localparam int LINE_NS_2    = 22000;
  localparam int LINE_CYC_1   = LINE_NS_1 / CLK_NS;
  localparam int LINE_CYC_2   = LINE_NS_2 / CLK_NS;
  // Level scale: input in tenths of a percent of the 100% level
  localparam int LVL_100 = 1000;
  localparam int LVL_115 = 1150;
  localparam logic [11:0] SETUP_8  = 12'h008;
  localparam logic [11:0] SETUP_10 = 12'h020;
  localparam logic [11:0] SETUP_12 = 12'h080;
  localparam logic [11:0] WHITE_8  = 12'h0DE;
  localparam logic [11:0] WHITE_10 = 12'h37A;
  localparam logic [11:0] WHITE_12 = 12'hDE8;
  localparam logic [11:0] FULL_8   = 12'h0FF;
  localparam logic [11:0] FULL_10  = 12'h3FF;
  localparam logic [11:0] FULL_12  = 12'hFFF;
  // Pixel packing, one-hot
  typedef enum logic [4:0] {
    PK_MONO8  = 5'h01, PK_PACK10 = 5'h02, PK_WIDE16 = 5'h04,
    PK_YUV422 = 5'h08, PK_RGB24  = 5'h10
  } packing_e;
  // Window seen by the readout and packet stages
  typedef struct packed {
    logic [10:0] h_start;
    logic [10:0] v_start;
    logic [10:0] width;
    logic [10:0] height;
    logic [10:0] ob_side;
    logic        bin_h;
    logic        bin_v;
  } window_s;
  // Whole state of the block
  typedef struct packed {
    window_s     win;
    logic [12:0] pitch;
    packing_e    packing;
    logic [1:0]  depth;
    logic [11:0] flines;
    logic [10:0] line_cnt;
    logic [11:0] row;
    logic        line_tick;
    logic        frame_start;
    logic [31:0] rdata;
    logic [11:0] code;
    logic        code_valid;
  } state_s;
endpackage

/* hdl/readout_window.sv */
// Readout window, binning, frame timing and output level mapping
//
// The address map and the strobed register port were left to the implementer.
module readout_window #(
  parameter bit MONO = 1'b1 // Binning exists only on monochrome
) (
  input  wire logic                 REF_CLK,
  input  wire logic                 RST_B,
  input  wire logic [7:0]           ADDR,
  input  wire logic [31:0]          WDATA,
  input  wire logic                 WR,
  input  wire logic                 RD,
  output logic [31:0]               RDATA,
  input  wire logic [10:0]          LEVEL_IN,
  input  wire logic                 LEVEL_VALID,
  output logic [11:0]               CODE,
  output logic                      CODE_VALID,
  output readout_pkg::window_s      WINDOW,
  output logic [11:0]               FRAME_LINES,
  output logic                      LINE_TICK,
  output logic                      FRAME_START
);
  readout_pkg::state_s st;      // Registered state
  readout_pkg::state_s next_st; // Next state

  // Byte pitch of a line from its pixel count
  function automatic logic [12:0] pitch_of(
    input logic [10:0] w, input readout_pkg::packing_e p);
    logic [13:0] w2;
    w2 = {3'h0, w} + {3'h0, w};
    unique case (p)
      readout_pkg::PK_MONO8:  pitch_of = {2'h0, w};
      readout_pkg::PK_PACK10: pitch_of = 13'((w2 + {3'h0, w}) >> 1);
      readout_pkg::PK_RGB24:  pitch_of = 13'(w2 + {3'h0, w});
      default:                pitch_of = w2[12:0];
    endcase
  endfunction

  // Pixel count of a line from its byte pitch
  function automatic logic [12:0] width_of(
    input logic [12:0] b, input readout_pkg::packing_e p);
    unique case (p)
      readout_pkg::PK_MONO8:  width_of = b;
      readout_pkg::PK_PACK10: width_of = 13'(({1'b0, b} << 1) / 14'h0003);
      readout_pkg::PK_RGB24:  width_of = 13'(b / 13'h0003);
      default:                width_of = b >> 1;
    endcase
  endfunction

  // Smaller of a value and a limit
  function automatic logic [10:0] clamp(
    input logic [12:0] v, input logic [10:0] lim);
    clamp = (v > {2'h0, lim}) ? lim : v[10:0];
  endfunction

  // Output code of a level for one bit depth
  function automatic logic [11:0] level_code(input logic [10:0] lvl,
    input logic [11:0] setup, input logic [11:0] white,
    input logic [11:0] full);
    logic [23:0] span;
    span = 24'(lvl) * 24'(white - setup) / 24'(readout_pkg::LVL_100);
    if (lvl >= 11'(readout_pkg::LVL_115) ||
        span + 24'(setup) > 24'(full))
      level_code = full;
    else
      level_code = 12'(span) + setup;
  endfunction

  // Working values of the combinational process
  logic [10:0]        max_w;   // Width limit for the binning now set
  logic [10:0]        max_h;   // Height limit for the binning now set
  logic signed [15:0] s;       // Vertical start, signed
  logic signed [15:0] c;       // Line count, signed
  logic signed [15:0] fl;      // Frame line count
  logic [11:0]        setup;   // Black setup code at current depth
  logic [11:0]        white;   // 100% code at current depth
  logic [11:0]        full;    // Full scale at current depth
  logic [10:0]        line_cyc; // Clock cycles in one line
  logic [12:0]        wnew;    // Candidate width on a write
  logic               bh;      // Horizontal binning after a write
  logic               bv;      // Vertical binning after a write

  // Next state: register writes, frame arithmetic, timing, levels
  always_comb begin
    next_st = st;
    wnew = 13'h0000;
    bh = st.win.bin_h;
    bv = st.win.bin_v;
    max_w = st.win.bin_h ? readout_pkg::MAX_W_2 : readout_pkg::MAX_W_1;
    max_h = st.win.bin_v ? readout_pkg::MAX_H_2 : readout_pkg::MAX_H_1;
    next_st.line_tick = 1'b0;
    next_st.frame_start = 1'b0;
    next_st.code_valid = 1'b0;
    next_st.rdata = 32'h0000_0000;
    // Register writes; the slave never stalls
    if (WR) begin
      unique case (ADDR)
        readout_pkg::OFS_H_START:
          next_st.win.h_start = clamp(WDATA[12:0], max_w);
        readout_pkg::OFS_V_START:
          next_st.win.v_start = clamp(WDATA[12:0], max_h);
        readout_pkg::OFS_WIDTH: begin
          next_st.win.width = clamp(WDATA[12:0], max_w);
          next_st.pitch = pitch_of(next_st.win.width, st.packing);
        end
        readout_pkg::OFS_HEIGHT:
          next_st.win.height = clamp(WDATA[12:0], max_h);
        readout_pkg::OFS_PITCH: begin
          wnew = width_of(WDATA[12:0], st.packing);
          next_st.win.width = clamp(wnew, max_w);
          next_st.pitch = pitch_of(next_st.win.width, st.packing);
        end
        readout_pkg::OFS_PACKING: begin
          // Illegal codes are dropped, keeping the enum one-hot
          unique case (WDATA[4:0])
            5'h01, 5'h02, 5'h04, 5'h08, 5'h10: begin
              next_st.packing = readout_pkg::packing_e'(WDATA[4:0]);
              next_st.pitch = pitch_of(st.win.width,
                readout_pkg::packing_e'(WDATA[4:0]));
            end
            default: ;
          endcase
        end
        readout_pkg::OFS_BINNING: begin
          // Colour variant keeps both factors at one
          bh = MONO & WDATA[readout_pkg::BIN_H_BIT];
          bv = MONO & WDATA[readout_pkg::BIN_V_BIT];
          next_st.win.bin_h = bh;
          next_st.win.bin_v = bv;
          // Shrinking limits pull values in; growing leaves them
          if (bh) begin
            next_st.win.width = clamp({2'h0, st.win.width},
                                      readout_pkg::MAX_W_2);
            next_st.win.h_start = clamp({2'h0, st.win.h_start},
                                        readout_pkg::MAX_W_2);
            next_st.pitch = pitch_of(next_st.win.width, st.packing);
          end
          if (bv) begin
            next_st.win.height = clamp({2'h0, st.win.height},
                                       readout_pkg::MAX_H_2);
            next_st.win.v_start = clamp({2'h0, st.win.v_start},
                                        readout_pkg::MAX_H_2);
          end
        end
        readout_pkg::OFS_DEPTH:
          // Code 3 has no depth and is ignored
          if (WDATA[1:0] != 2'h3) next_st.depth = WDATA[1:0];
        default: ; // Unmapped and read-only offsets ignore writes
      endcase
    end
    // Side margin width follows horizontal binning
    next_st.win.ob_side = next_st.win.bin_h ?
      readout_pkg::OB_SIDE_BIN : readout_pkg::OB_SIDE_FULL;
    // Frame line count, arithmetic shift gives floor by four
    s = 16'(st.win.v_start);
    c = 16'(st.win.height);
    if (!st.win.bin_v) begin
      if (s < 16'sd4)
        fl = ((16'sd1203 - (c + s - 16'sd4)) >>> 2) +
             (c - (16'sd4 - s)) + 16'(readout_pkg::FL_ADD_LO);
      else
        fl = ((s + 16'sd3) >>> 2) +
             ((16'sd1203 - (c + s - 16'sd4)) >>> 2) +
             c + 16'(readout_pkg::FL_ADD_HI);
    end else begin
      if (s < 16'sd4)
        fl = ((16'sd1203 - (((c - (16'sd4 - s)) <<< 1) +
              ((s <<< 1) - 16'sd4))) >>> 2) +
             (c - (16'sd4 - s)) + 16'(readout_pkg::FL_ADD_BIN);
      else
        fl = ((s + 16'sd3) >>> 2) +
             ((16'sd1203 - ((c <<< 1) + (s <<< 1) - 16'sd4)) >>> 2) +
             c + 16'(readout_pkg::FL_ADD_BIN - 1);
    end
    next_st.flines = (fl < 16'sd1) ? 12'h001 : fl[11:0];
    // Line and frame timing: period is lines times line time
    line_cyc = st.win.bin_v ? 11'(readout_pkg::LINE_CYC_2)
                            : 11'(readout_pkg::LINE_CYC_1);
    if (st.line_cnt >= line_cyc - 11'h001) begin
      next_st.line_cnt = 11'h000;
      next_st.line_tick = 1'b1;
      if (st.row >= st.flines - 12'h001) begin
        next_st.row = 12'h000;
        next_st.frame_start = 1'b1;
      end else begin
        next_st.row = st.row + 12'h001;
      end
    end else begin
      next_st.line_cnt = st.line_cnt + 11'h001;
    end
    // Level to code at the selected depth
    unique case (st.depth)
      2'h1: begin
        setup = readout_pkg::SETUP_10;
        white = readout_pkg::WHITE_10;
        full = readout_pkg::FULL_10;
      end
      2'h2: begin
        setup = readout_pkg::SETUP_12;
        white = readout_pkg::WHITE_12;
        full = readout_pkg::FULL_12;
      end
      default: begin
        setup = readout_pkg::SETUP_8;
        white = readout_pkg::WHITE_8;
        full = readout_pkg::FULL_8;
      end
    endcase
    if (LEVEL_VALID) begin
      next_st.code = level_code(LEVEL_IN, setup, white, full);
      next_st.code_valid = 1'b1;
    end
    // Read data stand only in the cycle after the strobe
    if (RD) begin
      unique case (ADDR)
        readout_pkg::OFS_H_START: next_st.rdata = 32'(st.win.h_start);
        readout_pkg::OFS_V_START: next_st.rdata = 32'(st.win.v_start);
        readout_pkg::OFS_WIDTH:   next_st.rdata = 32'(st.win.width);
        readout_pkg::OFS_HEIGHT:  next_st.rdata = 32'(st.win.height);
        readout_pkg::OFS_PITCH:   next_st.rdata = 32'(st.pitch);
        readout_pkg::OFS_PACKING: next_st.rdata = 32'(st.packing);
        readout_pkg::OFS_BINNING:
          next_st.rdata = 32'({st.win.bin_v, st.win.bin_h});
        readout_pkg::OFS_DEPTH:   next_st.rdata = 32'(st.depth);
        readout_pkg::OFS_FLINES:  next_st.rdata = 32'(st.flines);
        readout_pkg::OFS_MARGIN:
          next_st.rdata = {16'h0000, 5'h00, st.win.ob_side} |
                          {5'h00, readout_pkg::OB_TOP, 16'h0000};
        default: next_st.rdata = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // State register, synchronous active-low reset
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      st <= '0;
      st.win.h_start <= readout_pkg::RST_H_START;
      st.win.v_start <= readout_pkg::RST_V_START;
      st.win.width <= readout_pkg::RST_WIDTH;
      st.win.height <= readout_pkg::RST_HEIGHT;
      st.win.ob_side <= readout_pkg::OB_SIDE_FULL;
      st.pitch <= {2'h0, readout_pkg::RST_WIDTH};
      st.packing <= readout_pkg::PK_MONO8;
      st.flines <= 12'h001;
    end else begin
      st <= next_st;
    end
  end

  // Ports straight from the state register
  assign RDATA = st.rdata;
  assign CODE = st.code;
  assign CODE_VALID = st.code_valid;
  assign WINDOW = st.win;
  assign FRAME_LINES = st.flines;
  assign LINE_TICK = st.line_tick;
  assign FRAME_START = st.frame_start;

  // Checks on the registered state
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  // Cycles since the last line tick, for the period check
  logic [10:0] gap;
  always_ff @(posedge REF_CLK) begin
    if (!RST_B || st.line_tick) gap <= 11'h000;
    else gap <= gap + 11'h001;
  end

  // A line cut short by reset or by a change of vertical binning has
  // no fixed length, so the period check skips the tick that ends it
  logic mixed;   // Line since the last tick not checkable
  logic bv_last; // Vertical binning one cycle ago
  always_ff @(posedge REF_CLK) begin
    bv_last <= st.win.bin_v;
    if (!RST_B) mixed <= 1'b1;
    else if (st.win.bin_v != bv_last) mixed <= 1'b1; // Change wins
    else if (st.line_tick) mixed <= 1'b0;
  end

  pitch_couple_a: assert property (
    $past(WR) |-> st.pitch == pitch_of(st.win.width, st.packing))
    else $error("Pitch and width out of step");
  width_max_a: assert property (
    st.win.width <= (st.win.bin_h ? readout_pkg::MAX_W_2
                                  : readout_pkg::MAX_W_1))
    else $error("Width above its maximum");
  height_max_a: assert property (
    st.win.height <= (st.win.bin_v ? readout_pkg::MAX_H_2
                                   : readout_pkg::MAX_H_1))
    else $error("Height above its maximum");
  side_margin_a: assert property (
    ##1 st.win.ob_side == (st.win.bin_h ? 11'h008 : 11'h010))
    else $error("Side margin wrong for binning");
  mono_only_a: assert property (
    WR && ADDR == readout_pkg::OFS_BINNING |=>
    st.win.bin_h == (MONO & $past(WDATA[readout_pkg::BIN_H_BIT])) &&
    st.win.bin_v == (MONO & $past(WDATA[readout_pkg::BIN_V_BIT])))
    else $error("Binning on colour variant");
  flines_hi_a: assert property (
    !st.win.bin_v && st.win.v_start == 11'd304 &&
    st.win.height == 11'd600 |=> st.flines == 12'd779)
    else $error("Frame lines wrong, unbinned high start");
  flines_lo_a: assert property (
    !st.win.bin_v && st.win.v_start == 11'd0 &&
    st.win.height == 11'd1204 |=> st.flines == 12'd1229)
    else $error("Frame lines wrong, unbinned low start");
  flines_bin_a: assert property (
    st.win.bin_v && st.win.v_start == 11'd0 &&
    st.win.height == 11'd604 |=> st.flines == 12'd625)
    else $error("Frame lines wrong, binned low start");
  line_period_a: assert property (
    st.line_tick && !mixed |->
    gap == (bv_last ? 11'd1099 : 11'd1001))
    else $error("Line period wrong");
  code_full_a: assert property (
    LEVEL_VALID && LEVEL_IN >= 11'd1150 |=>
    CODE_VALID && CODE == (st.depth == 2'h0 ? 12'h0FF :
                           st.depth == 2'h1 ? 12'h3FF : 12'hFFF))
    else $error("115 percent not at full scale");
  code_white_a: assert property (
    LEVEL_VALID && LEVEL_IN == 11'd1000 && st.depth == 2'h1
    |=> CODE == 12'd890)
    else $error("100 percent code wrong");
  read_gap_a: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
    else $error("Read data outside read cycle");

  frame_seen_c: cover property (st.frame_start);
  bin_both_c: cover property (st.win.bin_h && st.win.bin_v);
  pitch_wr_c: cover property (WR && ADDR == readout_pkg::OFS_PITCH);
endmodule

/* dv/line_sink.sv */
// Behavioural packet output stage: measures line spacing, frame marks
module line_sink (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 line_tick,
  input  wire logic                 frame_start,
  input  wire readout_pkg::window_s win,
  output int                        period,
  output int                        stray
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt; // Cycles since the last line mark

  // Line spacing is latched at each mark; the bench compares it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt    <= 1;
      period <= 0;
      stray  <= 0;
    end else begin
      if (line_tick === 1'b1) begin
        period <= cnt;
        cnt    <= 1;
      end else begin
        cnt <= cnt + 1;
      end
      // A frame mark must ride on a line mark, or the stage loses sync
      if (frame_start === 1'b1 && line_tick !== 1'b1) begin
        stray <= stray + 1;
      end
    end
  end
endmodule

/* dv/readout_window_tb_top.sv */
// Self-checking bench for the readout window block
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module readout_window_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 ref_clk  = 1'b0;
  logic                 rst_b    = 1'b0;
  logic [7:0]           addr     = 8'h00;
  logic [31:0]          wdata    = 32'h0;
  logic                 wr       = 1'b0;
  logic                 rd       = 1'b0;
  logic [31:0]          rdata;
  logic [10:0]          level_in = 11'h000;
  logic                 level_ok = 1'b0;
  logic [11:0]          code;
  logic                 code_ok;
  readout_pkg::window_s win;
  logic [11:0]          flines;
  logic                 tick;
  logic                 fstart;
  int                   period;
  int                   stray;
  int                   fails     = 0;
  int                   cmp_count = 0;
  int                   cyc       = 0;
  logic [31:0]          v;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  readout_window uut (.REF_CLK(ref_clk), .RST_B(rst_b), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LEVEL_IN(level_in),
    .LEVEL_VALID(level_ok), .CODE(code), .CODE_VALID(code_ok),
    .WINDOW(win), .FRAME_LINES(flines), .LINE_TICK(tick),
    .FRAME_START(fstart));

  line_sink sink (.clk(ref_clk), .rst_b(rst_b), .line_tick(tick),
    .frame_start(fstart), .win(win), .period(period), .stray(stray));

  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Frame lines worked out from the start and count; division truncates toward zero
  function automatic int fl(input int s, input int c, input bit vb);
    if (vb)
      return (1203 - (2 * (c - (4 - s)) + 2 * s - 4)) / 4 + c - 4 + s + 24;
    if (s < 4)
      return (1203 - (c + s - 4)) / 4 + (c - (4 - s)) + 29;
    return (s + 3) / 4 + (1203 - (c + s - 4)) / 4 + c + 28;
  endfunction

  // Reset values, margins, read-only and unmapped places
  task automatic t_reset();
    rd_reg(8'h00, v); `CHK(v, 32'd16)
    rd_reg(8'h04, v); `CHK(v, 32'd4)
    rd_reg(8'h08, v); `CHK(v, 32'd1600)
    rd_reg(8'h10, v); `CHK(v, 32'd1600)
    // Top margin included: start at line 0, four more lines
    wr_reg(8'h04, 32'd0);
    wr_reg(8'h0C, 32'd1204);
    rd_reg(8'h04, v); `CHK(v, 32'd0)
    rd_reg(8'h0C, v); `CHK(v, 32'd1204)
    wr_reg(8'h24, 32'h0);
    rd_reg(8'h24, v); `CHK(v, 32'h0004_0010)
    rd_reg(8'h30, v); `CHK(v, 32'h0)
    `CHK(win.ob_side, 11'd16)
    $display("test reset done");
  endtask

  // Frame line counts for both start cases and vertical binning
  task automatic t_flines();
    int s[5] = '{304, 0, 2, 0, 0};
    int c[5] = '{600, 1204, 600, 300, 604};
    bit b[5] = '{0, 0, 0, 1, 1};
    for (int i = 0; i < 5; i++) begin
      wr_reg(8'h18, {30'h0, b[i], 1'b0});
      wr_reg(8'h04, s[i]);
      wr_reg(8'h0C, c[i]);
      rd_reg(8'h20, v); `CHK(v, fl(s[i], c[i], b[i]))
      `CHK(flines, 12'(fl(s[i], c[i], b[i])))
    end
    wr_reg(8'h18, 32'h0);
    $display("test frame lines done");
  endtask

  // Width and pitch follow each other for every packing
  task automatic t_pitch();
    int pk[5] = '{1, 2, 4, 8, 16};
    int px[5] = '{800, 1200, 1600, 1600, 2400};
    // Width back from pitch plus one: only 8-bit keeps the extra byte
    int pw[5] = '{801, 800, 800, 800, 800};
    for (int i = 0; i < 5; i++) begin
      wr_reg(8'h14, pk[i]);
      wr_reg(8'h08, 32'd800);
      rd_reg(8'h10, v); `CHK(v, px[i])
      wr_reg(8'h10, px[i] + 1);
      rd_reg(8'h08, v); `CHK(v, pw[i])
    end
    wr_reg(8'h14, 32'h1);
    $display("test pitch done");
  endtask

  // Limits per binning factor; unbinning keeps the smaller values
  task automatic t_clamp();
    wr_reg(8'h08, 32'd2000);
    rd_reg(8'h08, v); `CHK(v, 32'd1632)
    wr_reg(8'h0C, 32'd2000);
    rd_reg(8'h0C, v); `CHK(v, 32'd1204)
    wr_reg(8'h18, 32'h3);
    rd_reg(8'h08, v); `CHK(v, 32'd816)
    rd_reg(8'h10, v); `CHK(v, 32'd816)
    rd_reg(8'h0C, v); `CHK(v, 32'd604)
    `CHK(win.ob_side, 11'd8)
    wr_reg(8'h00, 32'd8);
    rd_reg(8'h00, v); `CHK(v, 32'd8)
    wr_reg(8'h18, 32'h0);
    rd_reg(8'h08, v); `CHK(v, 32'd816)
    rd_reg(8'h0C, v); `CHK(v, 32'd604)
    $display("test clamp done");
  endtask

  // Setup, 100 percent and 115 percent codes at each depth
  task automatic t_level();
    logic [11:0] e[3][3] = '{'{12'd8, 12'd222, 12'd255},
      '{12'd32, 12'd890, 12'd1023}, '{12'd128, 12'd3560, 12'd4095}};
    logic [10:0] l[3] = '{11'd0, 11'd1000, 11'd1150};
    for (int d = 0; d < 3; d++) begin
      wr_reg(8'h1C, d);
      for (int k = 0; k < 3; k++) begin
        @(posedge ref_clk);
        level_in <= l[k];
        level_ok <= 1'b1;
        @(posedge ref_clk);
        level_ok <= 1'b0;
        #1 `CHK(code_ok, 1'b1)
        `CHK(code, e[d][k])
      end
    end
    $display("test level done");
  endtask

  // Line spacing with and without vertical binning
  task automatic t_tick();
    int w[2] = '{1002, 1100};
    for (int i = 0; i < 2; i++) begin
      wr_reg(8'h18, {30'h0, i[0], 1'b0});
      for (int n = 0; n < 3; n++) begin
        @(posedge ref_clk);
        while (tick !== 1'b1) @(posedge ref_clk);
      end
      #1 `CHK(period, w[i])
    end
    `CHK(stray, 0)
    $display("test line timing done");
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard well beyond the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_flines();
    t_pitch();
    t_clamp();
    t_level();
    t_tick();
    wrap_up();
  end
endmodule
